// ### rtl/adc_cfg_pkg.sv
package adc_cfg_pkg;

	// ********************************
	// serial word layout
	// ********************************
	localparam int          WORD_BITS    = 16;   // bits in one register write
	localparam int          CMD_MSB      = 15;   // command prefix top bit
	localparam int          CMD_LSB      = 11;   // command prefix low bit
	localparam logic [4:0]  CMD_CONFIG   = 5'h10; // converter_configuration write
	localparam logic [4:0]  CMD_SPAN     = 5'h13; // input_span_select write
	localparam logic [4:0]  CMD_SEQ_LEN  = 5'h18; // sequence length frame

	// ********************************
	// field positions
	// ********************************
	localparam int          BURST_MSB    = 6;    // burst_result_count
	localparam int          BURST_LSB    = 5;
	localparam int          PWR_MSB      = 4;    // static_powerdown_select
	localparam int          PWR_LSB      = 3;
	localparam int          ECHO_BIT     = 2;    // instruction echo enable
	localparam int          SPAN_MSB     = 10;   // pair 0/1 span
	localparam int          SPAN_LSB     = 3;    // pair 14/15 span
	localparam int          LEN_MSB      = 7;    // sequence length minus one
	localparam int          LEN_LSB      = 0;

	// ********************************
	// sizes and reset values
	// ********************************
	localparam int          PAIRS        = 8;    // adjacent input pairs
	localparam int          CHANNELS     = 16;   // analog inputs
	localparam int          SEQ_DEPTH    = 256;  // sequence entries
	localparam int          NIBBLE_BITS  = 4;    // bits per channel identifier
	localparam logic [1:0]  BURST_RESET  = 2'h0; // four-result bursts
	localparam logic [1:0]  PWR_RESET    = 2'h0; // fully powered
	localparam logic        ECHO_RESET   = 1'h0; // echo off
	localparam logic [7:0]  SPAN_RESET   = 8'h00; // half-reference spans
	localparam logic [3:0]  FIRST_INPUT  = 4'h0; // first_analog_input code

	// ********************************
	// power codes
	// ********************************
	localparam logic [1:0]  PWR_NORMAL   = 2'h0; // everything powered
	localparam logic [1:0]  PWR_FULL     = 2'h1; // full shutdown
	localparam logic [1:0]  PWR_PARTIAL  = 2'h2; // reference and buffer kept

	// scan modes, set by the scan control logic outside this block
	typedef enum logic [2:0] {
		HOST_PICKED,
		SAME_CHANNEL_BURST,
		ASCENDING_SCAN_EXT_CLOCK,
		ASCENDING_SCAN_INT_CLOCK,
		TOP_DOWN_SCAN_EXT_CLOCK,
		TOP_DOWN_SCAN_INT_CLOCK,
		MASKED_SCAN_EXT_CLOCK,
		MASKED_SCAN_INT_CLOCK
	} scan_mode_t;

	// serial pins as they arrive
	typedef struct packed {
		logic chipSelectN;  // frame, active low
		logic serialClock;  // link clock from the host
		logic serialDataIn; // host to device data
	} serial_pins_t;

	// pin levels between frames: chip-select high, link clock low, data high
	localparam serial_pins_t PINS_IDLE = 3'h5;

	// per-pair input configuration from the unipolar/bipolar registers
	typedef struct packed {
		logic [7:0] unipolarPairs; // pseudo-differential pairs
		logic [7:0] bipolarPairs;  // bipolar fully differential pairs
		logic       commonRef;     // all inputs referred to common input
	} pair_cfg_t;

endpackage : adc_cfg_pkg

// ### rtl/sync_2ff.sv
`timescale 1ns/100ps
module sync_2ff #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0   // level the input idles at
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             reset,
	// asynchronous side
	input  wire logic [WIDTH-1:0] asyncIn,
	// synchronised side
	output logic      [WIDTH-1:0] syncOut
);

	// two stages; the first is read only by the second
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_t;

	sync_state_t st_q;  // registered state
	sync_state_t st_d;  // next state

	// shift one stage per clock
	always_comb begin
		st_d        = st_q;
		st_d.stage1 = asyncIn;
		st_d.stage2 = st_q.stage1;
	end

	// register the stages
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			// idle level, so an edge detector sees no false edge after reset
			st_q <= '{stage1: RESET_VALUE, stage2: RESET_VALUE};
		end else begin
			st_q <= st_d;
		end
	end

	assign syncOut = st_q.stage2;

endmodule : sync_2ff

// ### rtl/adc_config_and_sequence_regs.sv
`timescale 1ns/100ps
// What this block does
// - burst code 00..11 gives 4..16 results
// - power code: normal, full, partial, unused
// - shutdown keeps every programmed register value
// - echo bit returns frame n word in n+1
// - echo starts one full frame after enabling
// - prefix 10011 writes the span register
// - span bits 10..3 pick pair half/full
// - span only matters for bipolar differential pairs
// - unipolar/bipolar pick coding, scan picks mode
// - same pair decision for every even/odd pair
// - index for single modes, mask for masked
// - sequence holds up to 256 entries
// - entries are 4-bit nibbles stored in order
// - length frame first, then pattern frame
// - new sequence active at next frame start
// - short pattern fills rest with first input
// - surplus pattern bits ignored until frame end
// - broken nibble stored as first input
// - prefix 10000 writes configuration word
module adc_config_and_sequence_regs (
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      reset,
	// serial pins
	input  wire adc_cfg_pkg::serial_pins_t pins,
	output logic                           serialDataOut,
	// pair configuration and scan control from neighbouring logic
	input  wire adc_cfg_pkg::pair_cfg_t    pairCfg,
	input  wire adc_cfg_pkg::scan_mode_t   scanMode,
	input  wire logic [3:0]                singleChannelIndex,
	input  wire logic [15:0]               customChannelMask,
	// configuration towards the converter
	output logic [1:0]                     burstResultCount,
	output logic [4:0]                     burstResults,
	output logic [1:0]                     staticPowerdownSelect,
	output logic                           fullShutdown,
	output logic                           partialShutdown,
	output logic                           echoEnabled,
	output logic [7:0]                     pairSpanSelect,
	output logic [7:0]                     pairFullSpan,
	output logic [7:0]                     pairDifferential,
	output logic [7:0]                     pairTwosComplement,
	output logic [15:0]                    channelSelect,
	// programmed sequence read port
	input  wire logic [7:0]                seqReadIndex,
	output logic [3:0]                     seqEntry,
	output logic [8:0]                     programmedSequenceLength,
	output logic                           sequenceActive
);

	// ********************************
	// state
	// ********************************
	typedef struct packed {
		logic             csnPrev;       // last synced chip-select
		logic             sclkPrev;      // last synced serial clock
		logic [15:0]      shiftIn;       // last sixteen bits received
		logic [10:0]      bitCount;      // bits in this frame, saturating
		logic             echoAtStart;   // echo bit as the frame began
		logic [15:0]      echoWord;      // instruction to return next frame
		logic             echoValid;     // echoWord holds a real word
		logic [15:0]      echoShift;     // outgoing echo bits
		logic [1:0]       burstCode;     // burst_result_count
		logic [1:0]       pwrSel;        // static_powerdown_select
		logic             echo;          // echo enable
		logic [7:0]       span;          // pair_span_select
		logic             expectPattern; // length frame seen
		logic             patternFrame;  // this frame carries nibbles
		logic [7:0]       loadLenM1;     // pending length minus one
		logic [255:0][3:0] loadSeq;      // sequence being loaded
		logic             pending;       // loaded, waiting to activate
		logic [255:0][3:0] activeSeq;    // sequence in use
		logic [7:0]       activeLenM1;   // active length minus one
		logic             seqActive;     // a sequence was activated
		logic [3:0]       seqEntry;      // read port data
		logic [4:0]       burstResults;  // decoded result count
		logic             fullOff;       // full shutdown decode
		logic             partOff;       // partial shutdown decode
		logic [7:0]       pairDiff;      // pair is differential
		logic [7:0]       pairTwos;      // pair codes two's complement
		logic [7:0]       spanEff;       // span actually applied
		logic [15:0]      chanSel;       // channel selection
	} state_t;

	state_t st_q;  // registered state
	state_t st_d;  // next state

	adc_cfg_pkg::serial_pins_t pinSync;  // pins after two flops

	// combinational helpers
	logic        csFall;      // frame begins
	logic        csRise;      // frame ends
	logic        sclkRise;    // sample edge inside a frame
	logic        sclkFall;    // launch edge inside a frame
	logic [15:0] newShift;    // shift register with the new bit
	logic        wordDone;    // sixteenth bit of a command frame
	logic        nibbleDone;  // fourth bit of a pattern nibble
	logic [8:0]  nibbleIdx;   // entry the current nibble belongs to
	logic [4:0]  cmd;         // prefix of the finished word

	// ********************************
	// pin synchronisers
	// ********************************
	sync_2ff #(
		.WIDTH       ($bits(adc_cfg_pkg::serial_pins_t)),
		.RESET_VALUE (adc_cfg_pkg::PINS_IDLE)
	) pinSyncInst (
		.clock   (clock),
		.reset   (reset),
		.asyncIn (pins),
		.syncOut (pinSync)
	);

	// ********************************
	// next-state logic
	// ********************************
	always_comb begin
		st_d        = st_q;
		csFall      = st_q.csnPrev & ~pinSync.chipSelectN;
		csRise      = ~st_q.csnPrev & pinSync.chipSelectN;
		sclkRise    = ~st_q.sclkPrev & pinSync.serialClock & ~pinSync.chipSelectN;
		sclkFall    = st_q.sclkPrev & ~pinSync.serialClock & ~pinSync.chipSelectN;
		newShift    = {st_q.shiftIn[14:0], pinSync.serialDataIn};
		wordDone    = sclkRise & ~st_q.patternFrame & (st_q.bitCount == 11'h00F);
		nibbleDone  = sclkRise & st_q.patternFrame & (st_q.bitCount[1:0] == 2'h3);
		nibbleIdx   = st_q.bitCount[10:2];
		cmd         = newShift[adc_cfg_pkg::CMD_MSB:adc_cfg_pkg::CMD_LSB];
		st_d.csnPrev  = pinSync.chipSelectN;
		st_d.sclkPrev = pinSync.serialClock;

		if (csFall) begin
			// frame start: clear counters, load echo
			st_d.bitCount     = '0;
			st_d.echoAtStart  = st_q.echo;
			st_d.echoShift    = st_q.echoValid ? st_q.echoWord : 16'h0000;
			st_d.patternFrame = st_q.expectPattern;
			st_d.expectPattern = 1'b0;
			if (st_q.pending) begin
				st_d.activeSeq   = st_q.loadSeq;
				st_d.activeLenM1 = st_q.loadLenM1;
				st_d.seqActive   = 1'b1;
				st_d.pending     = 1'b0;
			end
		end else if (csRise) begin
			// capture only if echo was on before frame
			st_d.echoValid = st_q.echoAtStart & ~st_q.patternFrame
				& (st_q.bitCount >= 11'h010);
			// keep frame n word for frame n+1
			st_d.echoWord  = st_q.shiftIn;
			if (st_q.patternFrame) begin
				for (int i = 0; i < adc_cfg_pkg::SEQ_DEPTH; i++) begin
					if (9'(i) >= nibbleIdx) begin
						st_d.loadSeq[i] = adc_cfg_pkg::FIRST_INPUT;
					end
				end
				st_d.pending      = 1'b1;
				st_d.patternFrame = 1'b0;
			end
		end else begin
			if (sclkRise) begin
				st_d.shiftIn = newShift;
				// saturate so long pattern frames never wrap
				if (st_q.bitCount != 11'h7FF) begin
					st_d.bitCount = st_q.bitCount + 11'h001;
				end
			end
			// launch echo bits on falling edge
			if (sclkFall) begin
				st_d.echoShift = {st_q.echoShift[14:0], 1'b0};
			end
			// store nibble at its arrival slot
			if (nibbleDone) begin
				if (nibbleIdx <= {1'b0, st_q.loadLenM1}) begin
					st_d.loadSeq[nibbleIdx[7:0]] = newShift[3:0];
				end
			end
			if (wordDone) begin
				case (cmd)
					adc_cfg_pkg::CMD_CONFIG: begin
						st_d.burstCode = newShift[adc_cfg_pkg::BURST_MSB:adc_cfg_pkg::BURST_LSB];
						st_d.pwrSel    = newShift[adc_cfg_pkg::PWR_MSB:adc_cfg_pkg::PWR_LSB];
						st_d.echo      = newShift[adc_cfg_pkg::ECHO_BIT];
					end
					adc_cfg_pkg::CMD_SPAN: begin
						st_d.span = newShift[adc_cfg_pkg::SPAN_MSB:adc_cfg_pkg::SPAN_LSB];
					end
					// length up to 256, first frame
					adc_cfg_pkg::CMD_SEQ_LEN: begin
						st_d.loadLenM1     = newShift[adc_cfg_pkg::LEN_MSB:adc_cfg_pkg::LEN_LSB];
						st_d.expectPattern = 1'b1;
					end
					// other prefixes belong to other registers
					default: begin
						st_d.expectPattern = st_q.expectPattern;
					end
				endcase
			end
		end

		// results = (code + 1) * 4
		st_d.burstResults = {3'(st_q.burstCode) + 3'h1, 2'b00};
		// power decode; code 11 powers nothing down
		st_d.fullOff = (st_q.pwrSel == adc_cfg_pkg::PWR_FULL);
		st_d.partOff = (st_q.pwrSel == adc_cfg_pkg::PWR_PARTIAL);
		// unipolar takes precedence, common ref overrides
		// same decision bitwise for all pairs
		st_d.pairDiff = (pairCfg.unipolarPairs | pairCfg.bipolarPairs)
			& {adc_cfg_pkg::PAIRS{~pairCfg.commonRef}};
		st_d.pairTwos = pairCfg.bipolarPairs & ~pairCfg.unipolarPairs
			& {adc_cfg_pkg::PAIRS{~pairCfg.commonRef}};
		// span only for bipolar differential pairs
		st_d.spanEff = st_q.span & pairCfg.bipolarPairs & ~pairCfg.unipolarPairs
			& {adc_cfg_pkg::PAIRS{~pairCfg.commonRef}};
		// index or mask by scan mode
		case (scanMode)
			adc_cfg_pkg::MASKED_SCAN_EXT_CLOCK,
			adc_cfg_pkg::MASKED_SCAN_INT_CLOCK: begin
				st_d.chanSel = customChannelMask;
			end
			default: begin
				st_d.chanSel = 16'h0001 << singleChannelIndex;
			end
		endcase
		st_d.seqEntry = st_q.activeSeq[seqReadIndex];
	end

	// ********************************
	// state register
	// ********************************
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			st_q           <= '0;
			st_q.csnPrev   <= 1'b1;
			st_q.burstCode <= adc_cfg_pkg::BURST_RESET;
			st_q.pwrSel    <= adc_cfg_pkg::PWR_RESET;
			st_q.echo      <= adc_cfg_pkg::ECHO_RESET;
			st_q.span      <= adc_cfg_pkg::SPAN_RESET;
			st_q.burstResults <= 5'h04;
		end else begin
			st_q <= st_d;
		end
	end

	// ********************************
	// outputs
	// ********************************
	assign serialDataOut            = st_q.echoShift[15];
	assign burstResultCount         = st_q.burstCode;
	assign burstResults             = st_q.burstResults;
	assign staticPowerdownSelect    = st_q.pwrSel;
	assign fullShutdown             = st_q.fullOff;
	assign partialShutdown          = st_q.partOff;
	assign echoEnabled              = st_q.echo;
	assign pairSpanSelect           = st_q.span;
	assign pairFullSpan             = st_q.spanEff;
	assign pairDifferential         = st_q.pairDiff;
	assign pairTwosComplement       = st_q.pairTwos;
	assign channelSelect            = st_q.chanSel;
	assign seqEntry                 = st_q.seqEntry;
	assign programmedSequenceLength = {1'b0, st_q.activeLenM1} + 9'h001;
	assign sequenceActive           = st_q.seqActive;

	// ********************************
	// checks
	// ********************************
	property p_burst_count;
		@(posedge clock) disable iff (reset)
		1'b1 |=> (burstResults == {3'($past(st_q.burstCode)) + 3'h1, 2'b00});
	endproperty
	a_burst_count: assert property (p_burst_count)
		else $error("burst result count mismatch");

	property p_power_decode;
		@(posedge clock) disable iff (reset)
		(st_q.pwrSel == 2'h3) |=> !fullShutdown && !partialShutdown;
	endproperty
	a_power_decode: assert property (p_power_decode)
		else $error("unused power code shut something down");

	property p_retain_in_shutdown;
		@(posedge clock) disable iff (reset)
		(st_q.pwrSel != 2'h0 && !wordDone) |=> $stable(st_q.span);
	endproperty
	a_retain_in_shutdown: assert property (p_retain_in_shutdown)
		else $error("span changed in shutdown without a write");

	property p_echo_load;
		@(posedge clock) disable iff (reset)
		(csFall && st_q.echoValid) |=> (st_q.echoShift == $past(st_q.echoWord));
	endproperty
	a_echo_load: assert property (p_echo_load)
		else $error("echo word not loaded at frame start");

	property p_echo_delay;
		@(posedge clock) disable iff (reset)
		(csRise && !st_q.echoAtStart) |=> !st_q.echoValid;
	endproperty
	a_echo_delay: assert property (p_echo_delay)
		else $error("echo armed before a full frame");

	property p_span_write;
		@(posedge clock) disable iff (reset)
		(wordDone && cmd == 5'h13) |=> (pairSpanSelect == $past(newShift[10:3]));
	endproperty
	a_span_write: assert property (p_span_write)
		else $error("span write not committed");

	property p_span_bipolar_only;
		@(posedge clock) disable iff (reset)
		1'b1 |=> ((pairFullSpan & ~$past(pairCfg.bipolarPairs)) == 8'h00);
	endproperty
	a_span_bipolar_only: assert property (p_span_bipolar_only)
		else $error("span applied to a non-bipolar pair");

	property p_mask_mode;
		@(posedge clock) disable iff (reset)
		(scanMode == adc_cfg_pkg::MASKED_SCAN_EXT_CLOCK)
			|=> (channelSelect == $past(customChannelMask));
	endproperty
	a_mask_mode: assert property (p_mask_mode)
		else $error("masked mode did not use the mask");

	property p_activate;
		@(posedge clock) disable iff (reset)
		(csFall && st_q.pending) |=> sequenceActive && !st_q.pending
			&& (st_q.activeLenM1 == $past(st_q.loadLenM1));
	endproperty
	a_activate: assert property (p_activate)
		else $error("sequence not activated at frame start");

	property p_fill_first;
		@(posedge clock) disable iff (reset)
		(csRise && st_q.patternFrame && nibbleIdx == 9'h000)
			|=> (st_q.loadSeq[0] == 4'h0) && st_q.pending;
	endproperty
	a_fill_first: assert property (p_fill_first)
		else $error("missing entry not set to first input");

	property p_surplus;
		@(posedge clock) disable iff (reset)
		(nibbleDone && nibbleIdx > {1'b0, st_q.loadLenM1}) |=> $stable(st_q.loadSeq);
	endproperty
	a_surplus: assert property (p_surplus)
		else $error("surplus nibble was stored");

	property p_config_write;
		@(posedge clock) disable iff (reset)
		(wordDone && cmd == 5'h10) |=> (echoEnabled == $past(newShift[2]))
			&& (staticPowerdownSelect == $past(newShift[4:3]));
	endproperty
	a_config_write: assert property (p_config_write)
		else $error("configuration write not committed");

endmodule : adc_config_and_sequence_regs

// ### sim/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model (
	// clock
	input  wire logic                 clock,
	// serial pins towards the device
	output adc_cfg_pkg::serial_pins_t pins,
	input  wire logic                 serialDataOut
);
	// ********************************
	// link timing
	// ********************************
	localparam int HALF_BIT = 8; // 160 ns link clock

	// idle: frame off, link clock parked low
	initial begin
		pins = '{chipSelectN: 1'b1, serialClock: 1'b0, serialDataIn: 1'b1};
	end

	// one frame; returns the last 16 bits seen on the device output
	task automatic send_frame(input int nBits, input logic [1023:0] bits,
		output logic [15:0] echo);
		logic lastBit;
		echo = 16'h0000;
		lastBit = 1'b1;
		@(posedge clock);
		pins.chipSelectN <= 1'b0;
		repeat (4) @(posedge clock);
		for (int i = nBits - 1; i >= 0; i--) begin
			lastBit = bits[i];
			pins.serialDataIn <= lastBit;
			repeat (HALF_BIT) @(posedge clock);
			pins.serialClock <= 1'b1;
			repeat (HALF_BIT) @(posedge clock);
			// sampled late in the high phase, output moves only after the fall
			echo = {echo[14:0], serialDataOut};
			pins.serialClock <= 1'b0;
		end
		repeat (4) @(posedge clock);
		pins.chipSelectN <= 1'b1;
		// released line must not keep showing the last bit
		pins.serialDataIn <= ~lastBit;
		repeat (6) @(posedge clock);
	endtask : send_frame
endmodule : serial_host_model

// ### sim/adc_config_and_sequence_regs_bench.sv
`timescale 1ns/100ps
module adc_config_and_sequence_regs_bench;
	// ********************************
	// signals
	// ********************************
	logic                      clock;        // 100 MHz
	logic                      reset;        // async, active high
	adc_cfg_pkg::serial_pins_t pins;         // driven by host model
	logic                      serialDataOut;
	adc_cfg_pkg::pair_cfg_t    pairCfg;
	adc_cfg_pkg::scan_mode_t   scanMode;
	logic [3:0]                singleChannelIndex;
	logic [15:0]               customChannelMask;
	logic [7:0]                seqReadIndex;
	logic [1:0]                burstResultCount;
	logic [4:0]                burstResults;
	logic [1:0]                staticPowerdownSelect;
	logic                      fullShutdown;
	logic                      partialShutdown;
	logic                      echoEnabled;
	logic [7:0]                pairSpanSelect;
	logic [7:0]                pairFullSpan;
	logic [7:0]                pairDifferential;
	logic [7:0]                pairTwosComplement;
	logic [15:0]               channelSelect;
	logic [3:0]                seqEntry;
	logic [8:0]                programmedSequenceLength;
	logic                      sequenceActive;
	int                        bad_count;    // mismatches
	int                        cmp_count;    // comparisons
	logic [31:0]               seed;         // xorshift state
	logic [15:0]               lastEcho;     // echo of the latest frame
	logic [7:0]                span;         // span value last written
	logic [15:0]               word1;        // word expected back as echo
	logic [3:0]                nib [256];    // pattern under test
	int                        curLen;       // active sequence length

	always #5 clock = ~clock;

	adc_config_and_sequence_regs adc_config_and_sequence_regs_i (.clock(clock), .reset(reset),
		.pins(pins), .serialDataOut(serialDataOut), .pairCfg(pairCfg), .scanMode(scanMode),
		.singleChannelIndex(singleChannelIndex), .customChannelMask(customChannelMask),
		.burstResultCount(burstResultCount), .burstResults(burstResults),
		.staticPowerdownSelect(staticPowerdownSelect), .fullShutdown(fullShutdown),
		.partialShutdown(partialShutdown), .echoEnabled(echoEnabled),
		.pairSpanSelect(pairSpanSelect), .pairFullSpan(pairFullSpan),
		.pairDifferential(pairDifferential), .pairTwosComplement(pairTwosComplement),
		.channelSelect(channelSelect), .seqReadIndex(seqReadIndex), .seqEntry(seqEntry),
		.programmedSequenceLength(programmedSequenceLength), .sequenceActive(sequenceActive));

	serial_host_model serial_host_model_i (.clock(clock), .pins(pins),
		.serialDataOut(serialDataOut));

	// ********************************
	// helpers and expectations
	// ********************************
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	function automatic logic [15:0] cfg_word(input logic [1:0] b, input logic [1:0] p,
		input logic e);
		return {adc_cfg_pkg::CMD_CONFIG, 4'h0, b, p, e, 2'h0};
	endfunction : cfg_word

	// masked modes take the mask, all others one-hot of the index
	function automatic logic [15:0] select_exp(input adc_cfg_pkg::scan_mode_t m,
		input logic [3:0] idx, input logic [15:0] mask);
		if (m == adc_cfg_pkg::MASKED_SCAN_EXT_CLOCK || m == adc_cfg_pkg::MASKED_SCAN_INT_CLOCK)
			return mask;
		return 16'h0001 << idx;
	endfunction : select_exp

	task automatic check(input string what, input logic [15:0] expVal, input logic [15:0] got);
		cmp_count++;
		if (got !== expVal) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, expVal, got);
		end
	endtask : check

	// entry read port answers one cycle after the index
	task automatic check_entry(input int k, input logic [3:0] expVal);
		seqReadIndex <= 8'(k);
		repeat (3) @(posedge clock);
		cmp_count++;
		if (seqEntry !== expVal) begin
			bad_count++;
			$display("ERROR seqEntry %0d expected %h seen %h", k, expVal, seqEntry);
		end
	endtask : check_entry

	task automatic wr(input logic [15:0] w);
		serial_host_model_i.send_frame(16, 1024'(w), lastEcho);
	endtask : wr

	// length frame, pattern frame, then a frame that activates
	task automatic load_seq(input int len, input int nNib, input int tailBits);
		logic [1023:0] v;
		int nBits;
		v = '1;
		nBits = 4 * nNib + tailBits;
		for (int k = 0; k < nNib; k++) v[nBits - 1 - 4 * k -: 4] = nib[k];
		wr({adc_cfg_pkg::CMD_SEQ_LEN, 3'h0, 8'(len - 1)});
		serial_host_model_i.send_frame(nBits, v, lastEcho);
		check("length before activation", 16'(curLen), 16'(programmedSequenceLength));
		wr(cfg_word(2'h0, 2'h0, 1'b0));
		curLen = len;
		check("programmedSequenceLength", 16'(len), 16'(programmedSequenceLength));
		check("sequenceActive", 16'h0001, 16'(sequenceActive));
		for (int k = 0; k < len; k++)
			check_entry(k, (k < nNib) ? nib[k] : adc_cfg_pkg::FIRST_INPUT);
	endtask : load_seq

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	// ********************************
	// watchdog
	// ********************************
	initial begin
		repeat (60000) @(posedge clock);
		bad_count++;
		print_verdict();
	end

	// ********************************
	// main sequence
	// ********************************
	initial begin
		clock = 1'b0; reset = 1'b1; bad_count = 0; cmp_count = 0; curLen = 1;
		seed = 32'h0000002A; pairCfg = '0; scanMode = adc_cfg_pkg::HOST_PICKED;
		singleChannelIndex = 4'h0; customChannelMask = 16'h0000; seqReadIndex = 8'h00;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		check("burstResults", 16'h0004, 16'(burstResults));
		check("config fields", 16'h0000, 16'({burstResultCount, staticPowerdownSelect}));
		check("span", 16'h0000, 16'(pairSpanSelect));
		check("echoEnabled", 16'h0000, 16'(echoEnabled));
		check("length", 16'h0001, 16'(programmedSequenceLength));
		check("sequenceActive", 16'h0000, 16'(sequenceActive));
		seed = xorshift(seed);
		span = seed[7:0] | 8'h81;
		wr({adc_cfg_pkg::CMD_SPAN, span, 3'h7});
		check("pairSpanSelect", 16'(span), 16'(pairSpanSelect));
		check("echo while off", 16'h0000, lastEcho);
		for (int c = 0; c < 16; c++) begin
			wr(cfg_word(2'(c >> 2), 2'(c), 1'b0));
			check("burstResultCount", 16'(c >> 2), 16'(burstResultCount));
			check("burstResults", 16'(4 * ((c >> 2) + 1)), 16'(burstResults));
			check("staticPowerdownSelect", 16'(c % 4), 16'(staticPowerdownSelect));
			check("fullShutdown", 16'(c % 4 == 1), 16'(fullShutdown));
			check("partialShutdown", 16'(c % 4 == 2), 16'(partialShutdown));
			check("span kept", 16'(span), 16'(pairSpanSelect));
		end
		// one bit short: nothing may commit
		serial_host_model_i.send_frame(15, 1024'(cfg_word(2'h1, 2'h1, 1'b0) >> 1), lastEcho);
		check("short frame", 16'h0003, 16'(burstResultCount));
		for (int i = 0; i < 12; i++) begin
			seed = xorshift(seed);
			@(posedge clock);
			pairCfg <= adc_cfg_pkg::pair_cfg_t'(seed[16:0] & {16'hFFFF, i[0]});
			scanMode <= adc_cfg_pkg::scan_mode_t'(3'(i));
			singleChannelIndex <= seed[20:17];
			customChannelMask <= seed[31:16];
			repeat (3) @(posedge clock);
			check("pairFullSpan", 16'(span & pairCfg.bipolarPairs & ~pairCfg.unipolarPairs
				& {8{~pairCfg.commonRef}}), 16'(pairFullSpan));
			check("pairDifferential", 16'((pairCfg.unipolarPairs | pairCfg.bipolarPairs)
				& {8{~pairCfg.commonRef}}), 16'(pairDifferential));
			check("pairTwosComplement", 16'(pairCfg.bipolarPairs & ~pairCfg.unipolarPairs
				& {8{~pairCfg.commonRef}}), 16'(pairTwosComplement));
			check("channelSelect", select_exp(scanMode, singleChannelIndex,
				customChannelMask), channelSelect);
		end
		for (int k = 0; k < 256; k++) begin
			seed = xorshift(seed);
			nib[k] = seed[3:0] | 4'h1;
		end
		load_seq(6, 4, 0);
		load_seq(2, 5, 0);
		load_seq(4, 2, 2);
		// corner: not one whole nibble, so every entry is the first input
		load_seq(3, 0, 3);
		load_seq(256, 256, 0);
		wr(cfg_word(2'h1, 2'h0, 1'b1));
		check("echoEnabled", 16'h0001, 16'(echoEnabled));
		word1 = {adc_cfg_pkg::CMD_SPAN, seed[11:4], 3'h0};
		wr(word1);
		check("first echo frame", 16'h0000, lastEcho);
		wr({adc_cfg_pkg::CMD_SPAN, span, 3'h0});
		check("echoed word", word1, lastEcho);
		wr(cfg_word(2'h0, 2'h0, 1'b0));
		wr(word1);
		wr(word1);
		check("echo after clear", 16'h0000, lastEcho);
		print_verdict();
	end
endmodule : adc_config_and_sequence_regs_bench
